// File: verilog/cbb_pkg.sv
/*
 * Constants and carrier types for the interrupt routing and bridge control
 * configuration registers of a PCI-to-CardBus bridge with three functions.
 * Assumes a configuration access slice that presents one dword access per
 * request, with function number, byte offset and byte enables.
 */
//
// Operation
// - interrupt line byte is fully writable per function, resets to FFh
// - untied interrupt pin reads 01h, 02h, 03h for functions 0, 1, 2
// - pair tie merges function 1 onto INTA; pins read 01h, 01h, 03h
// - tie-all joins all functions onto INTA; every pin reads 01h
// - bridge control bits 15..11 and 4 always read zero
// - bit 10 enables burst write posting, kept separately per socket
// - bits 9 and 8 mark memory windows 1 and 0 prefetchable, per socket
// - bit 7 routes card interrupts to PCI when 0, legacy IRQ when 1
// - bit 6 drives socket reset; resets to 1 so socket starts in reset
// - PCI bus reset also drives socket reset regardless of bit 6
// - bit 6 survives PCI bus reset; only global reset or nrst_i restores it
// - context bits survive PCI reset while PME is enabled
// - shared bit 5 turns socket master aborts into target abort, and into SERR when serr_enable_i is set
// - bit 3 forwards VGA address accesses across the bridge
// - bit 2 blocks I/O in last 768 bytes of each 1K under 64K
// - bit 1 forwards card system error onto PCI SERR, per socket
// - bit 0 reports socket parity errors on card parity error output
package cbb_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam int NUM_FUNC = 3;
    localparam int NUM_SOCK = 2;
    localparam logic [7:0] LINE_OFF = 8'h3C;
    localparam logic [7:0] PIN_OFF = 8'h3D;
    localparam logic [7:0] BCTL_OFF = 8'h3E;
    localparam logic [7:0] LINE_RST = 8'hFF;
    localparam logic [7:0] PIN_INTA = 8'h01;
    localparam logic [7:0] PIN_INTB = 8'h02;
    localparam logic [7:0] PIN_INTC = 8'h03;
    localparam logic [15:0] BCTL_RST = 16'h0340;
    localparam logic [15:0] BCTL_WR_MASK = 16'h07EF;
    localparam logic [15:0] BCTL_SHARED_MASK = 16'h0020;
    localparam logic [15:0] BCTL_SOCKET_RESET_OUT_MASK = 16'h0040;
    localparam logic [15:0] BCTL_CTX_MASK = 16'h0080;

    // ----------------------------------------------------------------
    // bridge control field positions
    // ----------------------------------------------------------------
    localparam int B_WRITE_POSTING_ON = 10;
    localparam int B_PF1 = 9;
    localparam int B_PF0 = 8;
    localparam int B_ROUTE = 7;
    localparam int B_SOCKET_RESET_OUT = 6;
    localparam int B_MABT = 5;
    localparam int B_VGA = 3;
    localparam int B_ISA = 2;
    localparam int B_SERR = 1;
    localparam int B_PERR = 0;

    // ----------------------------------------------------------------
    // isa alias window
    // ----------------------------------------------------------------
    localparam logic [9:0] ISA_BLOCK_BYTES = 10'h300;
    localparam logic [10:0] ISA_PAGE_BYTES = 11'h400;
    localparam logic [9:0] ISA_BLOCK_START = 10'(ISA_PAGE_BYTES - 11'(ISA_BLOCK_BYTES));

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic req;
        logic we;
        logic [1:0] func;
        logic [7:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } cbb_cfg_req_t;

    typedef struct packed {
        logic [NUM_FUNC-1:0][7:0] line;
        logic [NUM_SOCK-1:0][15:0] bctl;
        logic mabt;
        logic pci_bus_reset_in_s1;
        logic pci_bus_reset_in_s2;
        logic global_reset_in_s1;
        logic global_reset_in_s2;
        logic [NUM_SOCK-1:0] card_system_error_s1;
        logic [NUM_SOCK-1:0] card_system_error_s2;
        logic [NUM_SOCK-1:0] cint_s1;
        logic [NUM_SOCK-1:0] cint_s2;
        logic [NUM_SOCK-1:0] sock_rst;
        logic [NUM_FUNC-1:0] pci_int;
        logic [NUM_SOCK-1:0] legacy_irq;
        logic [NUM_SOCK-1:0] serr_fwd;
        logic [NUM_SOCK-1:0] perr_out;
        logic tabort;
        logic abort_serr;
        logic io_block;
        logic ack;
        logic [31:0] rdata;
    } cbb_state_t;

endpackage : cbb_pkg

// File: verilog/cbb_bridge_regs.sv
/*
 * Interrupt line, interrupt pin and bridge control registers for the three
 * functions of a CardBus bridge, with interrupt merging, socket reset and
 * the error, forwarding and alias controls that the bridge control steers.
 * Assumes configuration requests arrive on clock_i; reset and card pins are
 * asynchronous and are synchronised here.
 */
module cbb_bridge_regs #(
    parameter int FUNCS = 3,
    parameter int SOCKS = 2
) (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire cbb_pkg::cbb_cfg_req_t cfg_i,
    output logic cfg_ack_o,
    output logic [31:0] cfg_rdata_o,
    input wire logic global_reset_in_n_i,
    input wire logic pci_bus_reset_in_n_i,
    input wire logic pme_enable_i,
    input wire logic pair_irq_tie_i,
    input wire logic all_irq_tie_i,
    input wire logic [2:0] func_irq_i,
    input wire logic [1:0] card_func_irq_i,
    input wire logic [1:0] card_system_error_i,
    input wire logic [1:0] sock_parity_det_i,
    input wire logic master_abort_i,
    input wire logic serr_enable_i,
    input wire logic io_check_i,
    input wire logic io_sock_i,
    input wire logic [31:0] io_addr_i,
    output logic [1:0] socket_reset_out_o,
    output logic [2:0] pci_int_o,
    output logic [1:0] legacy_card_irq_o,
    output logic pci_serr_o,
    output logic target_abort_o,
    output logic [1:0] card_parity_error_o,
    output logic io_block_o,
    output logic [1:0] write_posting_on_o,
    output logic [1:0] window1_prefetchable_o,
    output logic [1:0] window0_prefetchable_o,
    output logic [1:0] functional_irq_route_sel_o,
    output logic [1:0] vga_forward_on_o,
    output logic [1:0] isa_alias_filter_on_o,
    output logic [1:0] card_syserr_forward_on_o,
    output logic [1:0] card_parity_report_on_o,
    output logic master_abort_report_sel_o
);

    // ----------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------
    if (FUNCS != cbb_pkg::NUM_FUNC || SOCKS != cbb_pkg::NUM_SOCK) begin : g_bad
        $error("cbb_bridge_regs serves exactly three functions and two sockets");
    end

    cbb_pkg::cbb_state_t st_ff;
    cbb_pkg::cbb_state_t nxt_st;

    logic hit;
    logic [15:0] lane_mask;
    logic [15:0] sock_mask;
    logic [15:0] keep_mask;
    logic [2:0] fn_irq;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------

    // interrupt pin value as seen by one function
    function automatic logic [7:0] pin_code(input logic [1:0] fn, input logic pair,
                                            input logic all);
        logic [7:0] code;
        code = 8'h00;
        if (all) begin
            code = cbb_pkg::PIN_INTA;
        end else if (fn == 2'd0) begin
            code = cbb_pkg::PIN_INTA;
        end else if (fn == 2'd1) begin
            code = pair ? cbb_pkg::PIN_INTA : cbb_pkg::PIN_INTB;
        end else if (fn == 2'd2) begin
            code = cbb_pkg::PIN_INTC;
        end
        return code;
    endfunction : pin_code

    // bridge control as read back, shared bit folded in
    function automatic logic [15:0] bctl_view(input logic [15:0] own, input logic shared);
        logic [15:0] v;
        v = own & cbb_pkg::BCTL_WR_MASK & ~cbb_pkg::BCTL_SHARED_MASK;
        v[cbb_pkg::B_MABT] = shared;
        return v;
    endfunction : bctl_view

    // ----------------------------------------------------------------
    // address decode and write masks
    // ----------------------------------------------------------------

    // one dword holds line, pin and bridge control
    assign hit = (cfg_i.addr[7:2] == cbb_pkg::LINE_OFF[7:2]);
    assign lane_mask = {{8{cfg_i.be[3]}}, {8{cfg_i.be[2]}}};
    // shared bit is kept apart, reserved bits never stored
    assign sock_mask = cbb_pkg::BCTL_WR_MASK & ~cbb_pkg::BCTL_SHARED_MASK & lane_mask;
    // bits that survive a pci bus reset
    assign keep_mask = cbb_pkg::BCTL_SOCKET_RESET_OUT_MASK | (pme_enable_i ? cbb_pkg::BCTL_CTX_MASK : 16'h0000);

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------

    // internal function interrupts, card interrupts joined when pci routed
    always_comb begin
        fn_irq = func_irq_i;
        for (int s = 0; s < cbb_pkg::NUM_SOCK; s++) begin
            if (!st_ff.bctl[s][cbb_pkg::B_ROUTE]) begin
                fn_irq[s] = func_irq_i[s] | st_ff.cint_s2[s];
            end
        end
    end

    // one process computes every next value
    always_comb begin
        nxt_st = st_ff;

        // pin synchronisers, second stage feeds the logic
        nxt_st.global_reset_in_s1 = ~global_reset_in_n_i;
        nxt_st.global_reset_in_s2 = st_ff.global_reset_in_s1;
        nxt_st.pci_bus_reset_in_s1 = ~pci_bus_reset_in_n_i;
        nxt_st.pci_bus_reset_in_s2 = st_ff.pci_bus_reset_in_s1;
        nxt_st.card_system_error_s1 = card_system_error_i;
        nxt_st.card_system_error_s2 = st_ff.card_system_error_s1;
        nxt_st.cint_s1 = card_func_irq_i;
        nxt_st.cint_s2 = st_ff.cint_s1;

        // configuration read answer, one cycle after the request
        nxt_st.ack = cfg_i.req;
        nxt_st.rdata = 32'h0000_0000;
        if (cfg_i.req && hit && cfg_i.func != 2'd3) begin
            nxt_st.rdata[7:0] = st_ff.line[cfg_i.func];
            nxt_st.rdata[15:8] = pin_code(cfg_i.func, pair_irq_tie_i, all_irq_tie_i);
            if (cfg_i.func != 2'd2) begin
                nxt_st.rdata[31:16] = bctl_view(st_ff.bctl[cfg_i.func[0]], st_ff.mabt);
            end
        end

        // configuration write; pin byte is read-only
        if (cfg_i.req && cfg_i.we && hit && cfg_i.func != 2'd3) begin
            if (cfg_i.be[0]) begin
                nxt_st.line[cfg_i.func] = cfg_i.wdata[7:0];
            end
            if (cfg_i.func != 2'd2) begin
                // each socket holds its own copy
                nxt_st.bctl[cfg_i.func[0]] = (st_ff.bctl[cfg_i.func[0]] & ~sock_mask)
                                           | (cfg_i.wdata[31:16] & sock_mask);
                if (cfg_i.be[2]) begin
                    nxt_st.mabt = cfg_i.wdata[16 + cbb_pkg::B_MABT];
                end
            end
        end

        // pci bus reset: socket reset bit and live context bits survive
        if (st_ff.pci_bus_reset_in_s2) begin
            nxt_st.line = {cbb_pkg::NUM_FUNC{cbb_pkg::LINE_RST}};
            nxt_st.mabt = 1'b0;
            for (int s = 0; s < cbb_pkg::NUM_SOCK; s++) begin
                nxt_st.bctl[s] = (st_ff.bctl[s] & keep_mask)
                               | (cbb_pkg::BCTL_RST & ~keep_mask);
            end
        end

        // global reset restores everything
        if (st_ff.global_reset_in_s2) begin
            nxt_st.line = {cbb_pkg::NUM_FUNC{cbb_pkg::LINE_RST}};
            nxt_st.bctl = {cbb_pkg::NUM_SOCK{cbb_pkg::BCTL_RST & ~cbb_pkg::BCTL_SHARED_MASK}};
            nxt_st.mabt = 1'b0;
        end

        // socket reset from control bit or pci bus reset
        for (int s = 0; s < cbb_pkg::NUM_SOCK; s++) begin
            nxt_st.sock_rst[s] = st_ff.bctl[s][cbb_pkg::B_SOCKET_RESET_OUT]
                               | st_ff.pci_bus_reset_in_s2;
        end

        // interrupt merging onto the pci lines
        nxt_st.pci_int = fn_irq;
        if (all_irq_tie_i) begin
            nxt_st.pci_int = {2'b00, |fn_irq};
        end else if (pair_irq_tie_i) begin
            nxt_st.pci_int = {fn_irq[2], 1'b0, fn_irq[1] | fn_irq[0]};
        end

        // legacy irq path for card interrupts, card system error forward and parity report
        for (int s = 0; s < cbb_pkg::NUM_SOCK; s++) begin
            nxt_st.legacy_irq[s] = st_ff.bctl[s][cbb_pkg::B_ROUTE] & st_ff.cint_s2[s];
            nxt_st.serr_fwd[s] = st_ff.bctl[s][cbb_pkg::B_SERR] & st_ff.card_system_error_s2[s];
            nxt_st.perr_out[s] = st_ff.bctl[s][cbb_pkg::B_PERR] & sock_parity_det_i[s];
        end

        // master abort on the socket bus
        nxt_st.tabort = master_abort_i & st_ff.mabt;
        nxt_st.abort_serr = master_abort_i & st_ff.mabt & serr_enable_i;

        // isa alias filter on i/o cycles below 64K
        nxt_st.io_block = io_check_i
                        & st_ff.bctl[io_sock_i][cbb_pkg::B_ISA]
                        & (io_addr_i[31:16] == 16'h0000)
                        & (io_addr_i[9:0] >= cbb_pkg::ISA_BLOCK_START);
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------

    // async reset to constants, clock enable freezes all state
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_ff <= '0;
            st_ff.line <= {cbb_pkg::NUM_FUNC{cbb_pkg::LINE_RST}};
            st_ff.bctl <= {cbb_pkg::NUM_SOCK{cbb_pkg::BCTL_RST & ~cbb_pkg::BCTL_SHARED_MASK}};
            st_ff.sock_rst <= '1;
        end else if (ce_i) begin
            st_ff <= nxt_st;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------

    // answers and events, all from flops
    assign cfg_ack_o = st_ff.ack;
    assign cfg_rdata_o = st_ff.rdata;
    assign socket_reset_out_o = st_ff.sock_rst;
    assign pci_int_o = st_ff.pci_int;
    assign legacy_card_irq_o = st_ff.legacy_irq;
    assign pci_serr_o = (|st_ff.serr_fwd) | st_ff.abort_serr;
    assign target_abort_o = st_ff.tabort;
    assign card_parity_error_o = st_ff.perr_out;
    assign io_block_o = st_ff.io_block;
    assign master_abort_report_sel_o = st_ff.mabt;

    // per socket control levels
    for (genvar s = 0; s < cbb_pkg::NUM_SOCK; s++) begin : g_sock
        assign write_posting_on_o[s] = st_ff.bctl[s][cbb_pkg::B_WRITE_POSTING_ON];
        assign window1_prefetchable_o[s] = st_ff.bctl[s][cbb_pkg::B_PF1];
        assign window0_prefetchable_o[s] = st_ff.bctl[s][cbb_pkg::B_PF0];
        assign functional_irq_route_sel_o[s] = st_ff.bctl[s][cbb_pkg::B_ROUTE];
        assign vga_forward_on_o[s] = st_ff.bctl[s][cbb_pkg::B_VGA];
        assign isa_alias_filter_on_o[s] = st_ff.bctl[s][cbb_pkg::B_ISA];
        assign card_syserr_forward_on_o[s] = st_ff.bctl[s][cbb_pkg::B_SERR];
        assign card_parity_report_on_o[s] = st_ff.bctl[s][cbb_pkg::B_PERR];
    end

endmodule : cbb_bridge_regs

// File: verification/cbb_props_properties.sv
/*
 * checker for the bridge register block: pin report, reserved bits,
 * socket reset, abort, io filter and parity relations.
 * assumes it is bound to cbb_bridge_regs and sees only its ports.
 */
module cbb_props (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire cbb_pkg::cbb_cfg_req_t cfg_i,
    input wire logic cfg_ack_o,
    input wire logic [31:0] cfg_rdata_o,
    input wire logic pci_bus_reset_in_n_i,
    input wire logic pair_irq_tie_i,
    input wire logic all_irq_tie_i,
    input wire logic master_abort_i,
    input wire logic [1:0] sock_parity_det_i,
    input wire logic io_check_i,
    input wire logic io_sock_i,
    input wire logic [31:0] io_addr_i,
    input wire logic [1:0] socket_reset_out_o,
    input wire logic target_abort_o,
    input wire logic [1:0] card_parity_error_o,
    input wire logic io_block_o,
    input wire logic [1:0] isa_alias_filter_on_o,
    input wire logic [1:0] card_parity_report_on_o,
    input wire logic master_abort_report_sel_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------
    // relations
    // ----------------------------------------
    logic rd;
    // a read taken by a real function at the dword holding these registers
    assign rd = ce_i && cfg_i.req && !cfg_i.we && cfg_i.addr[7:2] == 6'h0F && cfg_i.func != 2'h3;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    property p_pin_free;
        rd && !pair_irq_tie_i && !all_irq_tie_i |=> cfg_rdata_o[15:8] == 8'($past(cfg_i.func)) + 8'h01;
    endproperty
    a_pin_free: assert property (p_pin_free) else $error("untied pin code wrong");
    property p_pin_pair;
        rd && pair_irq_tie_i && !all_irq_tie_i |=> cfg_rdata_o[15:8] == ($past(cfg_i.func) == 2'h2 ? 8'h03 : 8'h01);
    endproperty
    a_pin_pair: assert property (p_pin_pair) else $error("pair tie pin code wrong");
    property p_pin_all;
        rd && all_irq_tie_i |=> cfg_ack_o && cfg_rdata_o[15:8] == 8'h01;
    endproperty
    a_pin_all: assert property (p_pin_all) else $error("tie all pin code wrong");
    property p_rsvd;
        rd |=> cfg_rdata_o[31:27] == 5'h00 && !cfg_rdata_o[20];
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");
    property p_pci_bus_reset_in;
        (ce_i && !pci_bus_reset_in_n_i) [*5] |-> socket_reset_out_o == 2'h3;
    endproperty
    a_pci_bus_reset_in: assert property (p_pci_bus_reset_in) else $error("socket reset missing");
    property p_abort;
        ce_i |=> target_abort_o == $past(master_abort_i && master_abort_report_sel_o);
    endproperty
    a_abort: assert property (p_abort) else $error("target abort wrong");
    property p_io;
        ce_i && io_check_i |=> io_block_o == $past(isa_alias_filter_on_o[io_sock_i] &&
            io_addr_i[31:16] == 16'h0000 && io_addr_i[9:0] >= 10'h100);
    endproperty
    a_io: assert property (p_io) else $error("io filter wrong");
    property p_perr;
        ce_i |=> card_parity_error_o == $past(sock_parity_det_i & card_parity_report_on_o);
    endproperty
    a_perr: assert property (p_perr) else $error("parity report wrong");
    c_all: cover property (rd && all_irq_tie_i);
    c_abort: cover property (target_abort_o);
    c_io: cover property (io_block_o);
endmodule : cbb_props

bind cbb_bridge_regs cbb_props u_props (.clock_i, .nrst_i, .ce_i, .cfg_i, .cfg_ack_o, .cfg_rdata_o,
    .pci_bus_reset_in_n_i, .pair_irq_tie_i, .all_irq_tie_i, .master_abort_i, .sock_parity_det_i,
    .io_check_i, .io_sock_i, .io_addr_i, .socket_reset_out_o, .target_abort_o, .card_parity_error_o,
    .io_block_o, .isa_alias_filter_on_o, .card_parity_report_on_o, .master_abort_report_sel_o);

// File: verification/cbb_card_model.sv
/*
 * socket card model: raises interrupt and system error pins per socket.
 * assumes the bench commands it; pins idle low when not raised.
 */
module cbb_card_model (
    input wire logic [1:0] irq_cmd_i,
    input wire logic [1:0] serr_cmd_i,
    output logic [1:0] card_func_irq_o,
    output logic [1:0] card_system_error_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // card pins are asynchronous to the bridge clock
    assign card_func_irq_o = irq_cmd_i;
    assign card_system_error_o = serr_cmd_i;
endmodule : cbb_card_model

// File: verification/tb.sv
/*
 * bench for the bridge register block: table of pin and reset reads,
 * then writes, resets, abort, io filter, card pins and parity.
 * assumes the package and design files are compiled first.
 */
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------
    // signals and instances
    // ----------------------------------------
    typedef struct packed {
        logic pair;
        logic all;
        logic [1:0] f;
        logic [31:0] exp;
    } cbb_row_t;
    cbb_row_t rows [9] = '{'{1'h0, 1'h0, 2'h0, 32'h0340_01FF}, '{1'h0, 1'h0, 2'h1, 32'h0340_02FF},
        '{1'h0, 1'h0, 2'h2, 32'h0000_03FF}, '{1'h1, 1'h0, 2'h0, 32'h0340_01FF},
        '{1'h1, 1'h0, 2'h1, 32'h0340_01FF}, '{1'h1, 1'h0, 2'h2, 32'h0000_03FF},
        '{1'h1, 1'h1, 2'h0, 32'h0340_01FF}, '{1'h0, 1'h1, 2'h1, 32'h0340_01FF},
        '{1'h1, 1'h1, 2'h2, 32'h0000_01FF}};
    logic clock_i = 1'h0;
    logic nrst_i, ce_i, global_reset_in_n_i, pci_bus_reset_in_n_i, pme_enable_i, pair_irq_tie_i;
    logic all_irq_tie_i, master_abort_i, io_check_i, io_sock_i, cfg_ack_o, pci_serr_o, serr_enable_i;
    logic target_abort_o, io_block_o, master_abort_report_sel_o;
    cbb_pkg::cbb_cfg_req_t cfg_i;
    logic [31:0] io_addr_i, cfg_rdata_o;
    logic [1:0] card_func_irq_i, card_system_error_i, sock_parity_det_i, irq_cmd, serr_cmd;
    logic [1:0] socket_reset_out_o, legacy_card_irq_o, card_parity_error_o, write_posting_on_o;
    logic [1:0] isa_alias_filter_on_o, window1_prefetchable_o, window0_prefetchable_o, vga_forward_on_o;
    logic [1:0] functional_irq_route_sel_o;
    logic [2:0] pci_int_o, func_irq_i;
    int failures = 0;
    int tests_run = 0;
    int cycles = 0;
    cbb_bridge_regs DUT (.clock_i, .nrst_i, .ce_i, .cfg_i, .cfg_ack_o, .cfg_rdata_o, .global_reset_in_n_i,
        .pci_bus_reset_in_n_i, .pme_enable_i, .pair_irq_tie_i, .all_irq_tie_i, .func_irq_i,
        .card_func_irq_i, .card_system_error_i, .sock_parity_det_i, .master_abort_i, .serr_enable_i,
        .io_check_i, .io_sock_i, .io_addr_i, .socket_reset_out_o, .pci_int_o, .legacy_card_irq_o,
        .pci_serr_o, .target_abort_o, .card_parity_error_o, .io_block_o, .write_posting_on_o,
        .window1_prefetchable_o, .window0_prefetchable_o, .functional_irq_route_sel_o,
        .vga_forward_on_o, .isa_alias_filter_on_o, .card_syserr_forward_on_o(),
        .card_parity_report_on_o(), .master_abort_report_sel_o);
    cbb_card_model u_card (.irq_cmd_i(irq_cmd), .serr_cmd_i(serr_cmd), .card_func_irq_o(card_func_irq_i),
        .card_system_error_o(card_system_error_i));
    // clock and hang limit
    always #25 clock_i = ~clock_i;
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 2000) begin
            failures++;
            summarize();
        end
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic summarize;
        $display("failures=%0d tests_run=%0d", failures, tests_run);
        if (failures == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : summarize
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // one config access; reads compare the answer
    task automatic cfg(input logic we, input logic [1:0] f, input logic [3:0] be, input logic [31:0] d,
        input logic [31:0] exp);
        @(negedge clock_i);
        cfg_i = '{1'h1, we, f, 8'h3C, be, d};
        @(negedge clock_i);
        cfg_i.req = 1'h0;
        chk(32'(cfg_ack_o), 32'h1);
        if (!we) begin
            chk(cfg_rdata_o, exp);
        end
    endtask : cfg
    task automatic io(input logic s, input logic [31:0] a, input logic e);
        @(negedge clock_i);
        {io_check_i, io_sock_i, io_addr_i} = {1'h1, s, a};
        @(negedge clock_i);
        io_check_i = 1'h0;
        chk(32'(io_block_o), 32'(e));
    endtask : io
    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        {ce_i, global_reset_in_n_i, pci_bus_reset_in_n_i, pme_enable_i} = 4'hF;
        {nrst_i, pair_irq_tie_i, all_irq_tie_i, master_abort_i, io_check_i, io_sock_i, serr_enable_i} = 7'h00;
        {io_addr_i, sock_parity_det_i, irq_cmd, serr_cmd, cfg_i, func_irq_i} = '0;
        repeat (3) @(negedge clock_i);
        nrst_i = 1'h1;
        foreach (rows[i]) begin
            {pair_irq_tie_i, all_irq_tie_i} = {rows[i].pair, rows[i].all};
            cfg(1'h0, rows[i].f, 4'h0, 32'h0, rows[i].exp);
        end
        {pair_irq_tie_i, all_irq_tie_i} = 2'h0;
        // function 1 also writes the shared bit, so bit 5 is written as 0 there to keep it clear
        cfg(1'h1, 2'h1, 4'hF, 32'hFFDF_FFFF, 32'h0);
        cfg(1'h0, 2'h1, 4'h0, 32'h0, 32'h07CF_02FF);
        chk(32'(write_posting_on_o), 32'h2);
        // shared abort mode set through function 0, socket reset bit kept
        cfg(1'h1, 2'h0, 4'h5, 32'h0060_000B, 32'h0);
        cfg(1'h0, 2'h0, 4'h0, 32'h0, 32'h0360_010B);
        {master_abort_i, serr_enable_i} = 2'h2;
        @(negedge clock_i);
        chk(32'({target_abort_o, pci_serr_o}), 32'h2);
        serr_enable_i = 1'h1;
        @(negedge clock_i);
        master_abort_i = 1'h0;
        chk(32'({target_abort_o, pci_serr_o}), 32'h3);
        cfg(1'h1, 2'h0, 4'h4, 32'h0, 32'h0);
        repeat (3) @(negedge clock_i);
        chk(32'(socket_reset_out_o), 32'h2);
        // abort mode cleared: master aborts go unreported
        master_abort_i = 1'h1;
        @(negedge clock_i);
        master_abort_i = 1'h0;
        chk(32'({target_abort_o, pci_serr_o}), 32'h0);
        pci_bus_reset_in_n_i = 1'h0;
        repeat (5) @(negedge clock_i);
        chk(32'(socket_reset_out_o), 32'h3);
        pci_bus_reset_in_n_i = 1'h1;
        repeat (5) @(negedge clock_i);
        chk(32'(socket_reset_out_o), 32'h2);
        cfg(1'h0, 2'h1, 4'h0, 32'h0, 32'h03C0_02FF);
        // power management off: the context bit falls back to its reset value
        pme_enable_i = 1'h0;
        pci_bus_reset_in_n_i = 1'h0;
        repeat (5) @(negedge clock_i);
        pci_bus_reset_in_n_i = 1'h1;
        repeat (5) @(negedge clock_i);
        cfg(1'h0, 2'h1, 4'h0, 32'h0, 32'h0340_02FF);
        global_reset_in_n_i = 1'h0;
        repeat (5) @(negedge clock_i);
        global_reset_in_n_i = 1'h1;
        repeat (5) @(negedge clock_i);
        chk(32'(socket_reset_out_o), 32'h3);
        cfg(1'h1, 2'h1, 4'hC, 32'h018E_0000, 32'h0);
        chk(32'(isa_alias_filter_on_o), 32'h2);
        chk(32'({window1_prefetchable_o, window0_prefetchable_o}), 32'h7);
        chk(32'(vga_forward_on_o), 32'h2);
        chk(32'(functional_irq_route_sel_o), 32'h2);
        io(1'h1, 32'h0000_00FF, 1'h0);
        io(1'h1, 32'h0000_0100, 1'h1);
        io(1'h1, 32'h0001_0100, 1'h0);
        io(1'h0, 32'h0000_07FF, 1'h0);
        // internal function interrupts through the three tie settings
        func_irq_i = 3'h2;
        @(negedge clock_i);
        chk(32'(pci_int_o), 32'h2);
        pair_irq_tie_i = 1'h1;
        @(negedge clock_i);
        chk(32'(pci_int_o), 32'h1);
        {pair_irq_tie_i, all_irq_tie_i, func_irq_i} = 5'h0C;
        @(negedge clock_i);
        chk(32'(pci_int_o), 32'h1);
        {all_irq_tie_i, func_irq_i} = 4'h0;
        {irq_cmd, serr_cmd} = 4'hE;
        repeat (5) @(negedge clock_i);
        chk(32'(legacy_card_irq_o), 32'h2);
        chk(32'(pci_int_o), 32'h1);
        chk(32'(pci_serr_o), 32'h1);
        {irq_cmd, serr_cmd} = 4'h0;
        cfg(1'h1, 2'h0, 4'h4, 32'h0001_0000, 32'h0);
        sock_parity_det_i = 2'h3;
        @(negedge clock_i);
        sock_parity_det_i = 2'h0;
        chk(32'(card_parity_error_o), 32'h1);
        // asynchronous reset in mid-run restores the reset values
        nrst_i = 1'h0;
        @(negedge clock_i);
        chk(32'(socket_reset_out_o), 32'h3);
        nrst_i = 1'h1;
        cfg(1'h0, 2'h0, 4'h0, 32'h0, 32'h0340_01FF);
        summarize();
    end
endmodule : tb
